// file: verilog/irq_bank_cfg.svh
// Register map, field positions and reset values of the flag/enable bank
// How it works
// - Capture mode: a channel capture event sets its flag, bits 4..0.
// - Compare mode: a compare match sets that channel's flag.
// - Memory scanner event sets bit 7 of the memory service flags.
// - Checksum engine event sets bit 6 of the memory service flags.
// - Nonvolatile controller event sets bit 5; only software clears it.
// - Waveform generator event sets bit 0; bits 4..1 read zero.
// - Width acquisition of timers 2 and 1 sets bits 5 and 2.
// - Period acquisition of timers 2 and 1 sets bits 4 and 1.
// - General events of timers 2 and 1 set bits 3 and 0.
// - Flags reset to zero; a hardware set beats a software clear.
// - Group-0 enable bit 5 gates the timer-zero interrupt.
// - Group-0 enable bit 4 gates the pin change interrupt.
// - Group-0 enable bits 3..0 gate external interrupts 3..0.
// - Group-0 requests bypass the peripheral global enable.
// - Capture/compare enables share flag bit positions, 1 enables.
`ifndef IRQ_BANK_CFG_SVH
`define IRQ_BANK_CFG_SVH

// Printed offsets are not word multiples: indexes, byte address = 4*index
`define IDX_GROUP0_EN 12'he29
`define IDX_CAPCOMP_EN 12'he30
`define IDX_CAPCOMP_FLAGS 12'he3a
`define IDX_MEMSVC_FLAGS 12'he3b
`define IDX_SIGTMR_FLAGS 12'he3c
`define IDX_MEMSVC_EN 12'he3d
`define IDX_SIGTMR_EN 12'he3e
`define IDX_PERIPH_CTRL 12'he3f
`define IDX_STATUS 12'he40
`define IDX_MASK 12'he41

`define RESET_BYTE 8'h00
`define CAPCOMP_MASK 8'h1f
`define MEMSVC_MASK 8'he1
`define SIGTMR_MASK 8'h3f
`define GROUP0_MASK 8'h3f
`define STATUS_MASK 8'h0f

`define BIT_SCAN 7
`define BIT_CRC 6
`define BIT_NVM 5
`define BIT_WAVE 0
`define BIT_T2_WIDTH 5
`define BIT_T2_PERIOD 4
`define BIT_T2_GEN 3
`define BIT_T1_WIDTH 2
`define BIT_T1_PERIOD 1
`define BIT_T1_GEN 0
`define BIT_TMR0_EN 5
`define BIT_PINCHG_EN 4

// Sticky status bits
`define ST_CAPCOMP 0
`define ST_MEMSVC 1
`define ST_SIGTMR 2
`define ST_GROUP0 3

`define ADDR_LO 2
`define ADDR_HI 13
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010

`endif

// file: verilog/irq_bank_pkg.sv
// Types shared by the flag/enable bank
package irq_bank_pkg;
    typedef enum logic [1:0]
    {
        CCP_OFF,
        CCP_CAPTURE,
        CCP_COMPARE,
        CCP_PWM
    } capcomp_mode_t;
endpackage

// file: verilog/sticky_flag_reg.sv
// One byte of sticky hardware-set, software-written flags
`timescale 1ns/100ps
`include "irq_bank_cfg.svh"
module sticky_flag_reg
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] impl_mask_in,
    input wire logic [7:0] hw_set_in,
    input wire logic wr_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] flags_out
);
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_in)
        begin
            flags_nxt = wr_data_in;
        end
        // Set after write so a coinciding event is never lost
        flags_nxt = (flags_nxt | hw_set_in) & impl_mask_in;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            flags_r <= `RESET_BYTE;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_out = flags_r;
endmodule

// file: verilog/peripheral_irq_flag_enable_bank.sv
// AHB-Lite flag and enable bank for peripheral interrupt requests
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "irq_bank_cfg.svh"
module peripheral_irq_flag_enable_bank
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [9:0] capcomp_mode_in,
    input wire logic [4:0] capcomp_capture_in,
    input wire logic [4:0] capcomp_match_in,
    input wire logic memory_scanner_event_in,
    input wire logic checksum_engine_event_in,
    input wire logic nonvolatile_ctrl_event_in,
    input wire logic waveform_gen_event_in,
    input wire logic [1:0] meas_width_done_in,
    input wire logic [1:0] meas_period_done_in,
    input wire logic [1:0] meas_general_in,
    input wire logic timer_zero_flag_in,
    input wire logic pin_change_flag_in,
    input wire logic [3:0] external_flag_in,
    output logic [4:0] capcomp_req_out,
    output logic [7:0] memory_service_req_out,
    output logic [5:0] signal_timer_req_out,
    output logic timer_zero_req_out,
    output logic pin_change_req_out,
    output logic [3:0] external_req_out,
    output logic peripheral_req_out,
    output logic group0_req_out,
    output logic irq_out
);
    logic wr_pend_r;
    logic [11:0] wr_idx_r;
    logic [7:0] group0_irq_enables_r;
    logic [7:0] capcomp_irq_enable_r;
    logic [7:0] memory_service_irq_en_r;
    logic [7:0] signal_timer_irq_en_r;
    logic peripheral_global_enable_r;
    logic [7:0] status_r;
    logic [7:0] mask_r;
    logic [31:0] rdata_r;
    logic [7:0] capcomp_set;
    logic [7:0] memsvc_set;
    logic [7:0] sigtmr_set;
    logic [7:0] capcomp_irq_flags;
    logic [7:0] memory_service_irq_flags;
    logic [7:0] signal_timer_irq_flags;
    logic [7:0] wdata;
    logic [7:0] capcomp_pend;
    logic [7:0] memsvc_pend;
    logic [7:0] sigtmr_pend;
    logic [7:0] group0_pend;
    logic [7:0] status_set;
    logic [11:0] rd_idx;
    logic addr_phase;

    function automatic logic wr_hit(input logic [11:0] idx);
        wr_hit = wr_pend_r && (wr_idx_r == idx);
    endfunction

    function automatic irq_bank_pkg::capcomp_mode_t chan_mode
    (
        input logic [9:0] modes,
        input int ch
    );
        chan_mode = irq_bank_pkg::capcomp_mode_t'(modes[2*ch +: 2]);
    endfunction

    // Single-cycle slave: never stalls, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign addr_phase = hsel_in && hready_in && htrans_in[1];
    assign rd_idx = haddr_in[`ADDR_HI:`ADDR_LO];
    assign wdata = hwdata_in[7:0];

    // Address phase latched; write data lands in the data phase
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 12'h000;
        end
        else if (hready_in)
        begin
            wr_pend_r <= addr_phase && hwrite_in;
            wr_idx_r <= haddr_in[`ADDR_HI:`ADDR_LO];
        end
    end

    // Capture/compare event steering by channel mode
    always_comb
    begin
        capcomp_set = `RESET_BYTE;
        for (int ch = 0; ch < 5; ch++)
        begin
            case (chan_mode(capcomp_mode_in, ch))
                irq_bank_pkg::CCP_CAPTURE:
                    capcomp_set[ch] = capcomp_capture_in[ch];
                irq_bank_pkg::CCP_COMPARE:
                    capcomp_set[ch] = capcomp_match_in[ch];
                irq_bank_pkg::CCP_PWM:
                    capcomp_set[ch] = 1'b0;
                default:
                    capcomp_set[ch] = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        memsvc_set = `RESET_BYTE;
        memsvc_set[`BIT_SCAN] = memory_scanner_event_in;
        memsvc_set[`BIT_CRC] = checksum_engine_event_in;
        memsvc_set[`BIT_NVM] = nonvolatile_ctrl_event_in;
        memsvc_set[`BIT_WAVE] = waveform_gen_event_in;
    end

    always_comb
    begin
        sigtmr_set = `RESET_BYTE;
        sigtmr_set[`BIT_T2_WIDTH] = meas_width_done_in[1];
        sigtmr_set[`BIT_T1_WIDTH] = meas_width_done_in[0];
        sigtmr_set[`BIT_T2_PERIOD] = meas_period_done_in[1];
        sigtmr_set[`BIT_T1_PERIOD] = meas_period_done_in[0];
        sigtmr_set[`BIT_T2_GEN] = meas_general_in[1];
        sigtmr_set[`BIT_T1_GEN] = meas_general_in[0];
    end

    sticky_flag_reg u_capcomp_flags
    (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .impl_mask_in(`CAPCOMP_MASK),
        .hw_set_in(capcomp_set),
        .wr_in(wr_hit(`IDX_CAPCOMP_FLAGS)),
        .wr_data_in(wdata),
        .flags_out(capcomp_irq_flags)
    );

    sticky_flag_reg u_memsvc_flags
    (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .impl_mask_in(`MEMSVC_MASK),
        .hw_set_in(memsvc_set),
        .wr_in(wr_hit(`IDX_MEMSVC_FLAGS)),
        .wr_data_in(wdata),
        .flags_out(memory_service_irq_flags)
    );

    sticky_flag_reg u_sigtmr_flags
    (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .impl_mask_in(`SIGTMR_MASK),
        .hw_set_in(sigtmr_set),
        .wr_in(wr_hit(`IDX_SIGTMR_FLAGS)),
        .wr_data_in(wdata),
        .flags_out(signal_timer_irq_flags)
    );

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            group0_irq_enables_r <= `RESET_BYTE;
        end
        else if (wr_hit(`IDX_GROUP0_EN))
        begin
            group0_irq_enables_r <= wdata & `GROUP0_MASK;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            capcomp_irq_enable_r <= `RESET_BYTE;
        end
        else if (wr_hit(`IDX_CAPCOMP_EN))
        begin
            capcomp_irq_enable_r <= wdata & `CAPCOMP_MASK;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            memory_service_irq_en_r <= `RESET_BYTE;
            signal_timer_irq_en_r <= `RESET_BYTE;
            peripheral_global_enable_r <= 1'b0;
        end
        else
        begin
            if (wr_hit(`IDX_MEMSVC_EN))
            begin
                memory_service_irq_en_r <= wdata & `MEMSVC_MASK;
            end
            if (wr_hit(`IDX_SIGTMR_EN))
            begin
                signal_timer_irq_en_r <= wdata & `SIGTMR_MASK;
            end
            if (wr_hit(`IDX_PERIPH_CTRL))
            begin
                peripheral_global_enable_r <= wdata[0];
            end
        end
    end

    // Requests: flag AND enable; registered flags, but group 0 uses its raw flag inputs
    assign capcomp_pend = capcomp_irq_flags & capcomp_irq_enable_r;
    assign memsvc_pend = memory_service_irq_flags & memory_service_irq_en_r;
    assign sigtmr_pend = signal_timer_irq_flags & signal_timer_irq_en_r;
    assign group0_pend[7:6] = 2'b00;
    assign group0_pend[`BIT_TMR0_EN] = timer_zero_flag_in
        & group0_irq_enables_r[`BIT_TMR0_EN];
    assign group0_pend[`BIT_PINCHG_EN] = pin_change_flag_in
        & group0_irq_enables_r[`BIT_PINCHG_EN];
    assign group0_pend[3:0] = external_flag_in
        & group0_irq_enables_r[3:0];

    assign capcomp_req_out = capcomp_pend[4:0];
    assign memory_service_req_out = memsvc_pend;
    assign signal_timer_req_out = sigtmr_pend[5:0];
    assign timer_zero_req_out = group0_pend[`BIT_TMR0_EN];
    assign pin_change_req_out = group0_pend[`BIT_PINCHG_EN];
    assign external_req_out = group0_pend[3:0];
    // peripheral_req_out obeys the global enable; group 0 and the status bits do not
    assign peripheral_req_out = peripheral_global_enable_r
        & (|{capcomp_pend, memsvc_pend, sigtmr_pend});
    assign group0_req_out = |group0_pend;

    // Sticky summary status, write one to clear, set wins
    always_comb
    begin
        status_set = `RESET_BYTE;
        status_set[`ST_CAPCOMP] = |capcomp_pend;
        status_set[`ST_MEMSVC] = |memsvc_pend;
        status_set[`ST_SIGTMR] = |sigtmr_pend;
        status_set[`ST_GROUP0] = |group0_pend;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            status_r <= `RESET_BYTE;
        end
        else if (wr_hit(`IDX_STATUS))
        begin
            status_r <= ((status_r & ~wdata) | status_set) & `STATUS_MASK;
        end
        else
        begin
            status_r <= (status_r | status_set) & `STATUS_MASK;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            mask_r <= `RESET_BYTE;
        end
        else if (wr_hit(`IDX_MASK))
        begin
            mask_r <= wdata & `STATUS_MASK;
        end
    end

    assign irq_out = |(status_r & mask_r);

    // Read data sampled at the address phase, held in flops
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (addr_phase && !hwrite_in)
        begin
            case (rd_idx)
                `IDX_GROUP0_EN:
                    rdata_r <= {24'h000000, group0_irq_enables_r};
                `IDX_CAPCOMP_EN:
                    rdata_r <= {24'h000000, capcomp_irq_enable_r};
                `IDX_CAPCOMP_FLAGS:
                    rdata_r <= {24'h000000, capcomp_irq_flags};
                `IDX_MEMSVC_FLAGS:
                    rdata_r <= {24'h000000, memory_service_irq_flags};
                `IDX_SIGTMR_FLAGS:
                    rdata_r <= {24'h000000, signal_timer_irq_flags};
                `IDX_MEMSVC_EN:
                    rdata_r <= {24'h000000, memory_service_irq_en_r};
                `IDX_SIGTMR_EN:
                    rdata_r <= {24'h000000, signal_timer_irq_en_r};
                `IDX_PERIPH_CTRL:
                    rdata_r <= {31'h00000000, peripheral_global_enable_r};
                `IDX_STATUS:
                    rdata_r <= {24'h000000, status_r};
                `IDX_MASK:
                    rdata_r <= {24'h000000, mask_r};
                default:
                    rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata_out = rdata_r;
endmodule

// file: verification/event_source_model.sv
// Stand-in for the on-chip peripherals that raise events
`timescale 1ns/100ps
module event_source_model
(
    input wire logic clk_in,
    output logic [19:0] ev_out
);
    initial ev_out = 20'h0;
    // One-cycle pulses, launched just after an edge
    task automatic pulse(input logic [19:0] v);
        ev_out <= v;
        @(posedge clk_in);
        ev_out <= 20'h0;
    endtask
endmodule

// file: verification/irq_bank_properties.sv
// Port-level assertions of the flag and enable bank
`timescale 1ns/100ps
module irq_bank_properties
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [4:0] capcomp_capture_in,
    input wire logic [4:0] capcomp_match_in,
    input wire logic memory_scanner_event_in,
    input wire logic timer_zero_flag_in,
    input wire logic pin_change_flag_in,
    input wire logic [3:0] external_flag_in,
    input wire logic [4:0] capcomp_req_out,
    input wire logic [7:0] memory_service_req_out,
    input wire logic [5:0] signal_timer_req_out,
    input wire logic timer_zero_req_out,
    input wire logic pin_change_req_out,
    input wire logic [3:0] external_req_out,
    input wire logic peripheral_req_out,
    input wire logic group0_req_out,
    input wire logic irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic wr_dp_r;
    logic [18:0] req;
    assign req = {capcomp_req_out, memory_service_req_out, signal_timer_req_out};
    // Marks a write data phase; its closing edge commits the write
    always_ff @(posedge core_clk_in)
        if (sys_rst_in)
            wr_dp_r <= 1'b0;
        else
            wr_dp_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
    sequence s_no_write;
        !wr_dp_r;
    endsequence
    property p_bus_okay;
        hreadyout_out && !hresp_out;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus not ready or not okay");
    property p_reset_zero;
        $fell(sys_rst_in) |-> req == 19'h0 && !irq_out && hrdata_out == 32'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("state not cleared by reset");
    property p_gap;
        memory_service_req_out[4:1] == 4'h0 && hrdata_out[31:8] == 24'h0;
    endproperty
    a_gap: assert property (p_gap)
        else $error("unimplemented bits not zero");
    // Only a committed write may drop a flag or enable
    property p_sticky;
        s_no_write |=> &(req | ~$past(req));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("request dropped without a write");
    property p_scan_rise;
        $rose(memory_service_req_out[7]) |->
            $past(memory_scanner_event_in) || $past(wr_dp_r);
    endproperty
    a_scan_rise: assert property (p_scan_rise)
        else $error("scanner request without cause");
    property p_cc_rise;
        |(capcomp_req_out & ~$past(capcomp_req_out)) |-> $past(wr_dp_r)
            || |$past(capcomp_capture_in | capcomp_match_in);
    endproperty
    a_cc_rise: assert property (p_cc_rise)
        else $error("capture compare request without cause");
    property p_ext_gate;
        (external_req_out & ~external_flag_in) == 4'h0;
    endproperty
    a_ext_gate: assert property (p_ext_gate)
        else $error("external request without flag");
    property p_t0_gate;
        (!timer_zero_req_out || timer_zero_flag_in)
            && (!pin_change_req_out || pin_change_flag_in);
    endproperty
    a_t0_gate: assert property (p_t0_gate)
        else $error("group zero request without flag");
    property p_g0_or;
        group0_req_out == (timer_zero_req_out || pin_change_req_out
            || |external_req_out);
    endproperty
    a_g0_or: assert property (p_g0_or)
        else $error("group zero summary wrong");
    property p_periph;
        peripheral_req_out |-> |req;
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral request without source");
    property p_irq_rise;
        $rose(irq_out) |-> $past(wr_dp_r) || $past(|req || group0_req_out);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt without request");
endmodule

bind peripheral_irq_flag_enable_bank irq_bank_properties u_props
(
    .core_clk_in, .sys_rst_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in,
    .hrdata_out, .hreadyout_out, .hresp_out, .capcomp_capture_in,
    .capcomp_match_in, .memory_scanner_event_in, .timer_zero_flag_in,
    .pin_change_flag_in, .external_flag_in, .capcomp_req_out,
    .memory_service_req_out, .signal_timer_req_out, .timer_zero_req_out,
    .pin_change_req_out, .external_req_out, .peripheral_req_out,
    .group0_req_out, .irq_out
);

// file: verification/testbench.sv
// Self-checking bench of the flag and enable bank
`timescale 1ns/100ps
`include "irq_bank_cfg.svh"
module testbench;
    logic clk, rst, hsel, hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [9:0] mode;
    logic [5:0] g0;
    logic [19:0] ev;
    logic [7:0] rq;
    logic hrdy, hresp, t0req, pcreq, preq, g0req, irq;
    logic [4:0] ccreq;
    logic [7:0] msreq;
    logic [5:0] streq;
    logic [3:0] exreq;
    int tests_run = 0;
    int miscompares = 0;
    event_source_model src (.clk_in(clk), .ev_out(ev));
    peripheral_irq_flag_enable_bank dut (.core_clk_in(clk),
        .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(`HSIZE_WORD),
        .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp), .capcomp_mode_in(mode),
        .capcomp_capture_in(ev[19:15]), .capcomp_match_in(ev[14:10]),
        .memory_scanner_event_in(ev[9]), .checksum_engine_event_in(ev[8]),
        .nonvolatile_ctrl_event_in(ev[7]), .waveform_gen_event_in(ev[6]),
        .meas_width_done_in(ev[5:4]), .meas_period_done_in(ev[3:2]),
        .meas_general_in(ev[1:0]), .timer_zero_flag_in(g0[5]),
        .pin_change_flag_in(g0[4]), .external_flag_in(g0[3:0]),
        .capcomp_req_out(ccreq), .memory_service_req_out(msreq),
        .signal_timer_req_out(streq), .timer_zero_req_out(t0req),
        .pin_change_req_out(pcreq), .external_req_out(exreq),
        .peripheral_req_out(preq), .group0_req_out(g0req), .irq_out(irq));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Single word transfer; an event may be fired in the data phase
    task automatic ahb(input logic w, input logic [11:0] idx,
        input logic [7:0] d, input logic [19:0] e);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {18'h0, idx, 2'b00};
        @(posedge clk);
        while (hrdy !== 1'b1)
            @(posedge clk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        if (e !== 20'h0)
            fork
                src.pulse(e);
            join_none
        @(posedge clk);
        while (hrdy !== 1'b1)
            @(posedge clk);
        rq = hrdata[7:0];
    endtask
    task automatic t_regs();
        logic [11:0] ix[6] = '{`IDX_GROUP0_EN, `IDX_CAPCOMP_EN,
            `IDX_CAPCOMP_FLAGS, `IDX_MEMSVC_FLAGS, `IDX_SIGTMR_FLAGS, 12'hfff};
        logic [7:0] mk[6] = '{8'h3f, 8'h1f, 8'h1f, 8'he1, 8'h3f, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            ahb(0, ix[i], 8'h00, 20'h0);
            chk(rq, 8'h00);
            ahb(1, ix[i], 8'hff, 20'h0);
            ahb(0, ix[i], 8'h00, 20'h0);
            chk(rq, mk[i]);
            ahb(1, ix[i], 8'h00, 20'h0);
        end
        $display("t_regs done");
    endtask
    task automatic t_events();
        int m[10] = '{0, 3, 1, 4, 2, 5, 0, 5, 6, 7};
        logic [11:0] r;
        ahb(1, `IDX_SIGTMR_EN, 8'h3f, 20'h0);
        for (int i = 0; i < 10; i++)
        begin
            r = (i < 6) ? `IDX_SIGTMR_FLAGS : `IDX_MEMSVC_FLAGS;
            src.pulse(20'h1 << i);
            ahb(0, r, 8'h00, 20'h0);
            chk(rq, 8'h1 << m[i]);
            chk({2'h0, streq}, (i < 6) ? 8'h1 << m[i] : 8'h0);
            ahb(1, r, 8'h00, 20'h1 << i);
            ahb(0, r, 8'h00, 20'h0);
            chk(rq, 8'h1 << m[i]);
            ahb(1, r, 8'h00, 20'h0);
            ahb(0, r, 8'h00, 20'h0);
            chk(rq, 8'h00);
        end
        $display("t_events done");
    endtask
    // Every mode of every channel, capture and match fired apart
    task automatic t_capcomp();
        ahb(1, `IDX_CAPCOMP_EN, 8'h1f, 20'h0);
        for (int c = 0; c < 5; c++)
            for (int md = 0; md < 4; md++)
            begin
                mode <= 10'(md) << (2 * c);
                src.pulse(20'h1 << (15 + c));
                // Flags settle after the edge; look mid-cycle
                @(negedge clk);
                chk({3'h0, ccreq}, (md == 1) ? 8'h1 << c : 8'h0);
                @(posedge clk);
                ahb(0, `IDX_CAPCOMP_FLAGS, 8'h00, 20'h0);
                chk(rq, (md == 1) ? 8'h1 << c : 8'h0);
                ahb(1, `IDX_CAPCOMP_FLAGS, 8'h00, 20'h0);
                src.pulse(20'h1 << (10 + c));
                ahb(0, `IDX_CAPCOMP_FLAGS, 8'h00, 20'h0);
                chk(rq, (md == 2) ? 8'h1 << c : 8'h0);
                ahb(1, `IDX_CAPCOMP_FLAGS, 8'h00, 20'h0);
            end
        mode <= 10'h0;
        $display("t_capcomp done");
    endtask
    // Peripheral global enable stays off throughout
    task automatic t_group0();
        g0 <= 6'h3f;
        for (int b = 0; b < 7; b++)
        begin
            ahb(1, `IDX_GROUP0_EN, (b < 6) ? 8'h1 << b : 8'h0, 20'h0);
            @(negedge clk);
            chk({2'h0, t0req, pcreq, exreq}, (b < 6) ? 8'h1 << b : 8'h0);
            chk({7'h0, g0req}, (b < 6) ? 8'h1 : 8'h0);
            @(posedge clk);
        end
        ahb(1, `IDX_STATUS, 8'h0f, 20'h0);
        g0 <= 6'h00;
        $display("t_group0 done");
    endtask
    task automatic t_irq();
        ahb(1, `IDX_MEMSVC_EN, 8'h80, 20'h0);
        ahb(1, `IDX_MASK, 8'h00, 20'h0);
        src.pulse(20'h200);
        @(negedge clk);
        chk({msreq[7], preq, irq}, 3'b100);
        @(posedge clk);
        ahb(1, `IDX_PERIPH_CTRL, 8'h01, 20'h0);
        ahb(1, `IDX_MASK, 8'h02, 20'h0);
        @(negedge clk);
        chk({preq, irq}, 2'b11);
        @(posedge clk);
        ahb(1, `IDX_MEMSVC_FLAGS, 8'h00, 20'h0);
        ahb(1, `IDX_STATUS, 8'h02, 20'h0);
        @(negedge clk);
        chk({msreq[7], preq, irq}, 3'b000);
        @(posedge clk);
        ahb(0, `IDX_STATUS, 8'h00, 20'h0);
        chk(rq, 8'h00);
        $display("t_irq done");
    endtask
    task automatic complete_run();
        $display("tests %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Whole run is about 440 cycles; far past that means a hang
    initial
    begin
        #100000;
        miscompares++;
        complete_run();
    end
    initial
    begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, mode, g0} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_events();
        t_capcomp();
        t_group0();
        t_irq();
        complete_run();
    end
endmodule
